// ==== core/cpu_status_defs.svh ====
`ifndef CPU_STATUS_DEFS_SVH
`define CPU_STATUS_DEFS_SVH
// Function
// - an instruction that names status as destination and updates z, dc or c keeps its alu flags, not the written bits.
// - software writes never change the time-out or power-down bits.
// - a clear-file aimed at status clears the three bank bits, sets z and leaves the other bits alone.
// - power-down reads 1 after power-up or clear-watchdog and 0 after the sleep instruction.
// - z is set by an all-zero arithmetic or logic result and cleared by a nonzero one.
// - add and subtract instructions put the carry out of the low nibble into the nibble carry flag.
// - add and subtract instructions set carry on a carry out of bit 7 and clear it otherwise.
// - subtraction adds the two's complement, so carry and nibble carry read 1 when no borrow occurred.
// - rotates through carry load carry with the bit shifted out of the source operand.
// - the upper counter bits are reached only through a holding latch copied in when the low byte is written.
// - status and the other shared registers decode at the same offset in every bank.
// - port a pin 5 is input only and its direction bit always reads back as 1.
// - swap and move-to-register leave z, c and nibble carry untouched unless status is the destination, where the written bits land.

// ==========================================================
// register offsets within a bank (low seven address bits)
`define OFS_INDIRECT     7'h00
`define OFS_PC_LOW       7'h02
`define OFS_STATUS       7'h03
`define OFS_FSR          7'h04
`define OFS_PORTA        7'h05
`define OFS_PC_UPPER     7'h0A
`define OFS_INTCTL       7'h0B
// full address of the port a direction register (bank 1)
`define ADDR_PORTA_DIR   9'h085

// ==========================================================
// status field positions
`define ST_INDIRECT_BANK 7
`define ST_BANK_HI       6
`define ST_BANK_LO       5
`define ST_WDT_EXPIRY_N  4
`define ST_SLEEP_N       3
`define ST_ZERO          2
`define ST_NIBBLE_CARRY  1
`define ST_CARRY         0
`define PIN5_BIT         5

// ==========================================================
// reset values
`define STATUS_RESET     8'h18
`define PC_UPPER_RESET   5'h00
`define PORTA_DIR_RESET  8'hFF
`define READ_LATENCY     1
`endif

// ==== core/cpu_status_pkg.sv ====
package cpu_status_pkg;
  // ==========================================================
  // alu operations that the core hands to the status block
  typedef enum logic [3:0] {
    OP_ADD,
    OP_SUB,
    OP_AND,
    OP_IOR,
    OP_XOR,
    OP_CLR,
    OP_RLF,
    OP_RRF,
    OP_SWAP,
    OP_PASS,
    OP_INC,
    OP_DEC
  } alu_op_t;

  typedef logic [7:0] byte_t;
  typedef logic [8:0] data_addr_t;
endpackage : cpu_status_pkg

// ==== core/status_alu.sv ====
module status_alu
  import cpu_status_pkg::*;
(
  input  cpu_status_pkg::alu_op_t i_op,      // operation
  input  wire logic [7:0]         i_a,       // working operand or literal
  input  wire logic [7:0]         i_b,       // file operand
  input  wire logic               i_c,       // current carry
  output logic      [7:0]         o_res,     // result
  output logic                    o_z,       // zero out
  output logic                    o_dc,      // nibble carry out
  output logic                    o_c,       // carry out
  output logic                    o_upd_z,   // op updates zero
  output logic                    o_upd_dc,  // op updates nibble carry
  output logic                    o_upd_c    // op updates carry
);
  import cpu_status_pkg::*;

  // ==========================================================
  // shared adder: subtract is b plus the two's complement of a
  wire       is_sub = (i_op == OP_SUB);
  wire [7:0] a_sel  = is_sub ? ~i_a : i_a;
  wire [8:0] sum9   = {1'b0, i_b} + {1'b0, a_sel} + {8'h00, is_sub};
  wire [4:0] nib5   = {1'b0, i_b[3:0]} + {1'b0, a_sel[3:0]} + {4'h0, is_sub};
  wire       arith  = (i_op == OP_ADD) || is_sub;

  // ==========================================================
  // result selection and flag update masks
  always_comb begin
    o_res = i_b;
    o_c   = i_c;
    case (i_op)
      OP_ADD, OP_SUB: o_res = sum9[7:0];
      OP_AND:  o_res = i_a & i_b;
      OP_IOR:  o_res = i_a | i_b;
      OP_XOR:  o_res = i_a ^ i_b;
      OP_CLR:  o_res = 8'h00;
      OP_RLF: begin
        o_res = {i_b[6:0], i_c};
        o_c   = i_b[7];
      end
      OP_RRF: begin
        o_res = {i_c, i_b[7:1]};
        o_c   = i_b[0];
      end
      OP_SWAP: o_res = {i_b[3:0], i_b[7:4]};
      OP_INC:  o_res = i_b + 8'h01;
      OP_DEC:  o_res = i_b - 8'h01;
      default: o_res = i_b;
    endcase
    if (arith) begin
      o_c = sum9[8];
    end
  end

  assign o_z      = (o_res == 8'h00);
  assign o_dc     = nib5[4];
  // swap and pass (move) never touch a flag
  assign o_upd_z  = !(i_op == OP_SWAP || i_op == OP_PASS || i_op == OP_RLF
                      || i_op == OP_RRF);
  assign o_upd_dc = arith;
  assign o_upd_c  = arith || (i_op == OP_RLF) || (i_op == OP_RRF);
endmodule : status_alu

// ==== core/bank_decode.sv ====
`include "cpu_status_defs.svh"

module bank_decode
  import cpu_status_pkg::*;
(
  input  wire logic [6:0]            i_offset,     // offset within a bank
  input  wire logic                  i_indirect,   // use indirect pointer
  input  wire logic [7:0]            i_fsr,        // indirect pointer
  input  wire logic                  i_irp,        // indirect bank select
  input  wire logic [1:0]            i_rp,         // direct bank select
  output cpu_status_pkg::data_addr_t o_addr,       // full data address
  output logic                       o_hit_status, // status selected
  output logic                       o_hit_pcl,    // pc low byte selected
  output logic                       o_hit_pch,    // pc upper latch selected
  output logic                       o_hit_dir,    // port a direction selected
  output logic                       o_hit_port    // port a selected
);
  import cpu_status_pkg::*;

  // ==========================================================
  // bank 0..3 by rp code, or upper/lower half by irp for indirect
  assign o_addr = i_indirect ? {i_irp, i_fsr}
                             : {i_rp, i_offset};

  // shared registers ignore the bank bits entirely
  wire [6:0] low7 = o_addr[6:0];
  assign o_hit_status = (low7 == `OFS_STATUS);
  assign o_hit_pcl    = (low7 == `OFS_PC_LOW);
  assign o_hit_pch    = (low7 == `OFS_PC_UPPER);
  assign o_hit_dir    = (o_addr == `ADDR_PORTA_DIR);
  assign o_hit_port   = (o_addr[8:7] == 2'b00) && (low7 == `OFS_PORTA);
endmodule : bank_decode

// ==== core/cpu_status_register.sv ====
// The plain strobed port was left to the implementer.
`include "cpu_status_defs.svh"

module cpu_status_register
  import cpu_status_pkg::*;
(
  input  wire logic                  i_clk,          // core clock
  input  wire logic                  i_sys_rst,      // power-on reset, async high
  // register port
  input  wire logic [6:0]            i_addr,         // offset within bank
  input  wire logic                  i_indirect,     // address through pointer
  input  wire logic [7:0]            i_fsr,          // indirect pointer
  input  wire logic [7:0]            i_wdata,        // write data
  input  wire logic                  i_wr,           // plain write strobe
  input  wire logic                  i_rd,           // read strobe
  output logic      [7:0]            o_rdata,        // read data, next cycle
  // instruction execution
  input  wire logic                  i_alu_go,       // execute one alu op
  input  cpu_status_pkg::alu_op_t    i_alu_op,       // operation
  input  wire logic [7:0]            i_alu_a,        // working reg or literal
  input  wire logic [7:0]            i_alu_b,        // file operand
  input  wire logic                  i_alu_dest_f,   // result goes to the file
  output logic      [7:0]            o_alu_result,   // registered result
  // power management events
  input  wire logic                  i_clrwdt,       // clear-watchdog executed
  input  wire logic                  i_sleep,        // sleep executed
  input  wire logic                  i_wdt_expire,   // watchdog timed out
  // derived outputs
  output cpu_status_pkg::data_addr_t o_data_addr,    // full data address
  output logic      [4:0]            o_pc_upper,     // counter bits 12..8
  output logic                       o_pc_load,      // upper bits loaded
  input  wire logic                  i_pin5,         // input-only pin 5
  output logic      [7:0]            o_porta_dir,    // port a direction
  output logic      [7:0]            o_status        // status contents
);
  import cpu_status_pkg::*;

  // ==========================================================
  // state
  logic [2:0] bank_q, bank_d;       // irp, rp1, rp0
  logic       wdt_n_q, wdt_n_d;     // time-out bit
  logic       slp_n_q, slp_n_d;     // power-down bit
  logic       z_q, z_d;
  logic       dc_q, dc_d;
  logic       c_q, c_d;
  logic [4:0] pch_q, pch_d;         // holding latch for counter top
  logic [4:0] pcu_q;                // live counter top bits
  logic       pcl_ld_q;
  logic [7:0] dir_q, dir_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] res_q;

  // ==========================================================
  // address decode
  data_addr_t addr;
  logic hit_status, hit_pcl, hit_pch, hit_dir, hit_port;

  bank_decode u_decode (
    .i_offset     (i_addr),
    .i_indirect   (i_indirect),
    .i_fsr        (i_fsr),
    .i_irp        (bank_q[2]),
    .i_rp         (bank_q[1:0]),
    .o_addr       (addr),
    .o_hit_status (hit_status),
    .o_hit_pcl    (hit_pcl),
    .o_hit_pch    (hit_pch),
    .o_hit_dir    (hit_dir),
    .o_hit_port   (hit_port)
  );

  // ==========================================================
  // flag logic
  logic [7:0] alu_res;
  logic       alu_z, alu_dc, alu_c, upd_z, upd_dc, upd_c;

  status_alu u_alu (
    .i_op     (i_alu_op),
    .i_a      (i_alu_a),
    .i_b      (i_alu_b),
    .i_c      (c_q),
    .o_res    (alu_res),
    .o_z      (alu_z),
    .o_dc     (alu_dc),
    .o_c      (alu_c),
    .o_upd_z  (upd_z),
    .o_upd_dc (upd_dc),
    .o_upd_c  (upd_c)
  );

  // ==========================================================
  // status next value
  // an alu result with the file as destination is a write like any other;
  // the alu owns the flags it updates, so those bits of the write are lost
  wire        file_wr_alu = i_alu_go && i_alu_dest_f;
  wire        st_wr_alu   = file_wr_alu && hit_status;
  wire        st_wr_bus   = i_wr && hit_status && !i_alu_go;
  wire        st_wr       = st_wr_alu || st_wr_bus;
  wire [7:0]  st_wval     = st_wr_alu ? alu_res : i_wdata;
  wire        fz          = i_alu_go && upd_z;
  wire        fdc         = i_alu_go && upd_dc;
  wire        fc          = i_alu_go && upd_c;
  // an op that owns any flag blocks the write of all three, so a clear keeps c and dc
  wire        st_flag_wr  = st_wr_bus || (st_wr_alu && !(upd_z || upd_dc || upd_c));

  assign bank_d = st_wr ? st_wval[`ST_INDIRECT_BANK:`ST_BANK_LO] : bank_q;
  assign z_d    = fz  ? alu_z
                : st_flag_wr ? st_wval[`ST_ZERO] : z_q;
  assign dc_d   = fdc ? alu_dc
                : st_flag_wr ? st_wval[`ST_NIBBLE_CARRY] : dc_q;
  assign c_d    = fc  ? alu_c
                : st_flag_wr ? st_wval[`ST_CARRY] : c_q;

  // time-out and power-down move only on events, never on writes
  // watchdog expiry wins over a clear-watchdog in the same cycle
  assign wdt_n_d = i_wdt_expire ? 1'b0
                 : (i_clrwdt || i_sleep) ? 1'b1 : wdt_n_q;
  assign slp_n_d = i_sleep ? 1'b0
                 : i_clrwdt ? 1'b1 : slp_n_q;

  // ==========================================================
  // other registers: holding latch and port a direction
  wire        pch_wr = (file_wr_alu || (i_wr && !i_alu_go)) && hit_pch;
  wire        pcl_wr = (file_wr_alu || (i_wr && !i_alu_go)) && hit_pcl;
  wire        dir_wr = (file_wr_alu || (i_wr && !i_alu_go)) && hit_dir;
  wire [7:0]  fwval  = file_wr_alu ? alu_res : i_wdata;

  assign pch_d = pch_wr ? fwval[4:0] : pch_q;
  // pin 5 direction is forced to input whatever is written
  assign dir_d = dir_wr ? (fwval | (8'h01 << `PIN5_BIT)) : dir_q;

  // ==========================================================
  // read mux: counter top itself has no address, only its latch
  wire [7:0] status_word = {bank_q, wdt_n_q, slp_n_q, z_q, dc_q, c_q};
  always_comb begin
    rdata_d = 8'h00;
    if (!i_rd) begin
      rdata_d = 8'h00;
    end else if (hit_status) begin
      rdata_d = status_word;
    end else if (hit_pch) begin
      rdata_d = {3'b000, pch_q};
    end else if (hit_dir) begin
      rdata_d = dir_q | (8'h01 << `PIN5_BIT);
    end else if (hit_port) begin
      rdata_d = {2'b00, i_pin5, 5'b00000};
    end else begin
      rdata_d = 8'h00;
    end
  end

  // ==========================================================
  // status register flops; flags power up at zero
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {bank_q, wdt_n_q, slp_n_q, z_q, dc_q, c_q} <= `STATUS_RESET;
    end else begin
      bank_q  <= bank_d;
      wdt_n_q <= wdt_n_d;
      slp_n_q <= slp_n_d;
      z_q     <= z_d;
      dc_q    <= dc_d;
      c_q     <= c_d;
    end
  end

  // counter top copies the latch on a low-byte write
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pch_q    <= `PC_UPPER_RESET;
      pcu_q    <= `PC_UPPER_RESET;
      pcl_ld_q <= 1'b0;
    end else begin
      pch_q    <= pch_d;
      pcu_q    <= pcl_wr ? pch_q : pcu_q;
      pcl_ld_q <= pcl_wr;
    end
  end

  // direction, read data and result registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dir_q   <= `PORTA_DIR_RESET;
      rdata_q <= 8'h00;
      res_q   <= 8'h00;
    end else begin
      dir_q   <= dir_d;
      rdata_q <= rdata_d;
      res_q   <= i_alu_go ? alu_res : res_q;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata      = rdata_q;
  assign o_alu_result = res_q;
  assign o_data_addr  = addr;
  assign o_pc_upper   = pcu_q;
  assign o_pc_load    = pcl_ld_q;
  assign o_porta_dir  = dir_q;
  assign o_status     = status_word;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_pch_write;
    pch_wr ##1 !pch_wr;
  endsequence

  sequence s_pcl_write;
    pcl_wr && !pch_wr;
  endsequence

  a_flag_suppress: assert property (
    (st_wr_alu && upd_z && (i_alu_op != OP_CLR)) |=> (z_q == $past(alu_z)))
    else $error("status write overrode the alu zero flag");

  a_to_pd_locked: assert property (
    (st_wr && !i_clrwdt && !i_sleep && !i_wdt_expire)
      |=> $stable(wdt_n_q) && $stable(slp_n_q))
    else $error("software write changed time-out or power-down");

  a_clear_status: assert property (
    (st_wr_alu && i_alu_op == OP_CLR && !i_clrwdt && !i_sleep && !i_wdt_expire)
      |=> (bank_q == 3'b000) && z_q && $stable(dc_q) && $stable(c_q)
          && $stable(wdt_n_q) && $stable(slp_n_q))
    else $error("clear of status gave a wrong value");

  a_indirect_half: assert property (
    i_indirect |-> (o_data_addr[8] == bank_q[2]) && (o_data_addr[7:0] == i_fsr))
    else $error("indirect address ignores the bank bit");

  a_direct_bank: assert property (
    !i_indirect |-> (o_data_addr[8:7] == bank_q[1:0]) && (o_data_addr[6:0] == i_addr))
    else $error("direct address picks the wrong bank");

  a_sleep_pd: assert property (
    i_sleep |=> !slp_n_q && (wdt_n_q || $past(i_wdt_expire)))
    else $error("sleep did not clear power-down");

  a_clrwdt_pd: assert property (
    (i_clrwdt && !i_sleep) |=> slp_n_q)
    else $error("clear-watchdog did not set power-down");

  a_zero_flag: assert property (
    (i_alu_go && upd_z) |=> (z_q == ($past(alu_res) == 8'h00)))
    else $error("zero flag disagrees with the result");

  a_add_carry: assert property (
    (i_alu_go && i_alu_op == OP_ADD)
      |=> (c_q == ((9'({1'b0, $past(i_alu_a)}) + 9'({1'b0, $past(i_alu_b)})) > 9'h0FF))
          && (dc_q == (({1'b0, $past(i_alu_a[3:0])} + {1'b0, $past(i_alu_b[3:0])}) > 5'h0F)))
    else $error("add carry or nibble carry wrong");

  a_sub_borrow: assert property (
    (i_alu_go && i_alu_op == OP_SUB) |=> (c_q == ($past(i_alu_b) >= $past(i_alu_a))))
    else $error("subtract carry is not an inverted borrow");

  a_rotate_carry: assert property (
    (i_alu_go && i_alu_op == OP_RLF) |=> (c_q == $past(i_alu_b[7])))
    else $error("rotate left did not load carry from bit 7");

  a_pc_transfer: assert property (
    s_pch_write ##[0:4] s_pcl_write |=> (pcu_q == $past(pch_q)) && pcl_ld_q)
    else $error("counter top not loaded from the latch");

  a_shared_status: assert property (
    (!i_indirect && i_addr == `OFS_STATUS) |-> hit_status)
    else $error("status not decoded in the current bank");

  a_pin5_readback: assert property (
    (i_rd && hit_dir) |=> o_rdata[`PIN5_BIT] && o_porta_dir[`PIN5_BIT])
    else $error("pin 5 direction did not read as input");

  a_move_keeps_flags: assert property (
    (i_alu_go && (i_alu_op == OP_SWAP || i_alu_op == OP_PASS) && !st_wr_alu)
      |=> $stable(z_q) && $stable(c_q) && $stable(dc_q))
    else $error("swap or move changed a flag");

  a_wdt_expiry: assert property (
    i_wdt_expire |=> !wdt_n_q ##1 (wdt_n_q == $past(i_clrwdt || i_sleep) ||
                                   !wdt_n_q))
    else $error("watchdog expiry did not clear time-out");

  a_read_latency: assert property (
    (i_rd && hit_status && !st_wr && !i_alu_go && !i_clrwdt && !i_sleep
     && !i_wdt_expire) |=> (o_rdata == o_status))
    else $error("status read data not in the next cycle");

  // a flag left alone by an op that owns another flag keeps its value though status is the destination
  a_dc_suppress: assert property (
    (st_wr_alu && (upd_z || upd_c) && !upd_dc) |=> $stable(dc_q))
    else $error("status write reached the nibble carry flag");

  // same for carry, which a logic op aimed at status must not take from the result
  a_c_suppress: assert property (
    (st_wr_alu && (upd_z || upd_dc) && !upd_c) |=> $stable(c_q))
    else $error("status write reached the carry flag");

  // rotates own carry only, so the zero bit of the result is not written
  a_z_suppress: assert property (
    (st_wr_alu && upd_c && !upd_z) |=> $stable(z_q))
    else $error("status write reached the zero flag");

  // right rotate takes carry from the low bit
  a_rotate_right: assert property (
    (i_alu_go && i_alu_op == OP_RRF) |=> (c_q == $past(i_alu_b[0])))
    else $error("rotate right did not load carry from bit 0");

  // nibble carry reads as an inverted nibble borrow on subtract
  a_sub_nibble: assert property (
    (i_alu_go && i_alu_op == OP_SUB)
      |=> (dc_q == ($past(i_alu_b[3:0]) >= $past(i_alu_a[3:0]))))
    else $error("subtract nibble carry is not an inverted borrow");

  // a plain write is a move: bank bits and flags take the data as written
  a_bus_write: assert property (
    st_wr_bus |=> (bank_q == $past(i_wdata[7:5])) && ({z_q, dc_q, c_q} == $past(i_wdata[2:0])))
    else $error("plain status write did not land");

  // without a low-byte write the counter top and its load pulse stay quiet
  a_pc_hold: assert property (
    !pcl_wr |=> !o_pc_load && $stable(o_pc_upper))
    else $error("counter top moved without a low-byte write");

  // read data fall back to zero when no read was taken
  a_rdata_idle: assert property (
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data stood longer than one cycle");

  // the port read shows the pin itself in bit 5 and zero elsewhere
  a_port_pin5: assert property (
    (i_rd && hit_port) |=> (o_rdata == {2'b00, $past(i_pin5), 5'b00000}))
    else $error("port read does not show pin 5");

  // clear-watchdog or sleep sets time-out unless an expiry lands with it
  a_to_set: assert property (
    ((i_clrwdt || i_sleep) && !i_wdt_expire) |=> wdt_n_q)
    else $error("time-out not set by clear-watchdog or sleep");

  // counter low byte and its latch decode in every bank
  a_shared_pc: assert property (
    !i_indirect |-> (hit_pcl == (i_addr == `OFS_PC_LOW))
                    && (hit_pch == (i_addr == `OFS_PC_UPPER)))
    else $error("counter registers not decoded in the current bank");
endmodule : cpu_status_register

// ==== bench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_status_pkg::*;

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

  // ==========================================================
  // design ports and bench state
  logic       i_clk, i_sys_rst, i_indirect, i_wr, i_rd, i_alu_go, i_alu_dest_f;
  logic       i_clrwdt, i_sleep, i_wdt_expire, i_pin5, o_pc_load;
  logic [6:0] i_addr;
  logic [7:0] i_fsr, i_wdata, i_alu_a, i_alu_b, o_rdata, o_alu_result, o_porta_dir, o_status;
  logic [4:0] o_pc_upper;
  alu_op_t    i_alu_op;
  data_addr_t o_data_addr;
  int         n_mismatch = 0;
  int         cmp_count  = 0;
  int         cyc        = 0;
  logic [7:0] exp_st, rv, a8, f8;
  logic [6:0] ofs;
  alu_op_t    ops [4] = '{OP_ADD, OP_SUB, OP_RLF, OP_RRF};

  cpu_status_register i_cpu_status_register (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_indirect(i_indirect),
    .i_fsr(i_fsr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_alu_go(i_alu_go), .i_alu_op(i_alu_op), .i_alu_a(i_alu_a), .i_alu_b(i_alu_b),
    .i_alu_dest_f(i_alu_dest_f), .o_alu_result(o_alu_result), .i_clrwdt(i_clrwdt),
    .i_sleep(i_sleep), .i_wdt_expire(i_wdt_expire), .o_data_addr(o_data_addr),
    .o_pc_upper(o_pc_upper), .o_pc_load(o_pc_load), .i_pin5(i_pin5),
    .o_porta_dir(o_porta_dir), .o_status(o_status));

  // ==========================================================
  // clock and hang guard; the run needs well under a thousand cycles
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ==========================================================
  // bus and event drivers; each returns 1 ns after the edge that took it
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
    if (a == 7'h03) exp_st = {d[7:5], exp_st[4:3], d[2:0]};
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  task automatic ev(input logic cw, input logic sl, input logic ex);
    @(posedge i_clk);
    i_clrwdt     <= cw;
    i_sleep      <= sl;
    i_wdt_expire <= ex;
    @(posedge i_clk);
    i_clrwdt     <= 1'b0;
    i_sleep      <= 1'b0;
    i_wdt_expire <= 1'b0;
    #1;
    if (ex) exp_st[4] = 1'b0;
    else if (cw | sl) exp_st[4] = 1'b1;
    if (sl) exp_st[3] = 1'b0;
    else if (cw) exp_st[3] = 1'b1;
    `CHK(o_status, exp_st)
  endtask : ev

  // reference alu: subtract is b plus the two's complement of a
  task automatic alu(input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                     input logic dest);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic       z, dc, c;
    {z, dc, c} = exp_st[2:0];
    case (op)
      OP_ADD, OP_SUB: begin
        s  = (op == OP_ADD) ? {1'b0, b} + {1'b0, a} : {1'b0, b} + {1'b0, ~a} + 9'h001;
        h  = (op == OP_ADD) ? {1'b0, b[3:0]} + {1'b0, a[3:0]}
                            : {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        r  = s[7:0];
        z  = (r == 8'h00);
        dc = h[4];
        c  = s[8];
      end
      OP_RLF: begin
        r = {b[6:0], c};
        c = b[7];
      end
      OP_RRF: begin
        r = {c, b[7:1]};
        c = b[0];
      end
      default: begin
        r = 8'h00;
        z = 1'b1;
      end
    endcase
    @(posedge i_clk);
    i_alu_go     <= 1'b1;
    i_alu_op     <= op;
    i_alu_a      <= a;
    i_alu_b      <= b;
    i_alu_dest_f <= dest;
    i_addr       <= 7'h03;
    @(posedge i_clk);
    i_alu_go <= 1'b0;
    #1;
    exp_st[2:0] = {z, dc, c};
    if (dest) exp_st[7:5] = r[7:5];
    `CHK(o_alu_result, r)
    `CHK(o_status[2:0], {z, dc, c})
    `CHK(o_status, exp_st)
  endtask : alu

  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // main sequence
  initial begin
    {i_indirect, i_wr, i_rd, i_alu_go, i_alu_dest_f} = '0;
    {i_clrwdt, i_sleep, i_wdt_expire, i_pin5} = '0;
    {i_addr, i_fsr, i_wdata, i_alu_a, i_alu_b} = '0;
    i_alu_op  = OP_PASS;
    i_sys_rst = 1'b1;
    exp_st    = 8'h18;
    void'($urandom(12685));
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1;
    `CHK(o_status, 8'h18)
    `CHK(o_porta_dir, 8'hFF)
    `CHK(o_pc_upper, 5'h00)
    $display("test reset done");
    // plain writes reach flags and bank bits but never the two cause bits
    wr(7'h03, 8'hFF);
    `CHK(o_status, exp_st)
    wr(7'h03, 8'h00);
    `CHK(o_status, 8'h18)
    rd(7'h03, rv);
    `CHK(rv, 8'h18)
    ev(1'b0, 1'b0, 1'b1);
    wr(7'h03, 8'h1F);
    `CHK(o_status, 8'h0F)
    ev(1'b0, 1'b1, 1'b0);
    ev(1'b1, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b1);
    ev(1'b1, 1'b1, 1'b0);
    rd(7'h20, rv);
    `CHK(rv, 8'h00)
    $display("test status writes and events done");
    // every bank setting: status still decodes, direct and indirect addresses follow
    for (int k = 0; k < 8; k++) begin
      wr(7'h03, {k[2:0], 5'h00});
      `CHK(o_status, exp_st)
      ofs = 7'($urandom);
      f8  = 8'($urandom);
      @(posedge i_clk);
      i_addr <= ofs;
      #1;
      `CHK(o_data_addr, {k[1:0], ofs})
      @(posedge i_clk);
      i_indirect <= 1'b1;
      i_fsr      <= f8;
      #1;
      `CHK(o_data_addr, {k[2], f8})
      @(posedge i_clk);
      i_indirect <= 1'b0;
    end
    $display("test bank select done");
    // pin 5 stays an input whatever is written to its direction bit
    wr(7'h03, 8'h20);
    wr(7'h05, 8'h00);
    `CHK(o_porta_dir, 8'h20)
    rd(7'h05, rv);
    `CHK(rv, 8'h20)
    wr(7'h03, 8'h00);
    i_pin5 <= 1'b1;
    rd(7'h05, rv);
    `CHK(rv, 8'h20)
    // upper counter bits move only when the low byte is written
    wr(7'h0A, 8'h15);
    `CHK(o_pc_upper, 5'h00)
    wr(7'h02, 8'h33);
    `CHK({o_pc_load, o_pc_upper}, 6'h35)
    $display("test direction and counter latch done");
    // corner cases, then random add, subtract and rotates
    alu(OP_ADD, 8'hFF, 8'h01, 1'b0);
    alu(OP_SUB, 8'h05, 8'h05, 1'b0);
    alu(OP_SUB, 8'h01, 8'h00, 1'b0);
    alu(OP_RLF, 8'h00, 8'h80, 1'b0);
    alu(OP_RRF, 8'h00, 8'h01, 1'b0);
    for (int n = 0; n < 60; n++) begin
      a8 = 8'($urandom);
      f8 = 8'($urandom);
      alu(ops[$urandom % 4], a8, f8, 1'b0);
    end
    // status as destination: flags come from the alu, not from the result bits
    alu(OP_ADD, 8'hE1, 8'hFF, 1'b1); // leaves dc and c set so the clear must keep them
    alu(OP_CLR, 8'h00, 8'h00, 1'b1);
    $display("test alu flags done");
    stop_test();
  end

endmodule : tb
